/* src/nfc_pkg.sv */
package nfc_pkg;
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_COL_SETUP = 8'h05;
    localparam logic [7:0] CMD_COL_CONFIRM = 8'he0;
    localparam int CLK_MHZ = 20;
    localparam int PAGE_BYTES_X8 = 2112;
    localparam int PAGE_WORDS_X16 = 1056;
    localparam int READ_ITEMS = 7;
    localparam int JUMP_ITEMS = 4;
    localparam int COL_W = 12;
    localparam int ROW_W = 18;
    localparam int CNT_W = 12;
    localparam int SYNC_CYC = 3;
    localparam int WE_LOW_NS = 50;
    localparam int WE_HIGH_NS = 50;
    localparam int RE_HIGH_NS = 50;
    localparam int EDO_RE_LOW_NS = 200;
    localparam int READ_ACCESS_DELAY_NS = 100;
    localparam int BUSY_WAIT_NS = 500;
    localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int RE_HIGH_CYC = (RE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int EDO_RE_LOW_CYC = (EDO_RE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RE_LOW_CYC = (READ_ACCESS_DELAY_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC + 1;
    localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS * CLK_MHZ) / 1000;
    localparam int TMR_W = 8;
    typedef enum {
        NFC_IDLE,
        NFC_WE_LOW,
        NFC_WE_HIGH,
        NFC_WAIT_BUSY,
        NFC_WAIT_READY,
        NFC_RE_LOW,
        NFC_RE_HIGH,
        NFC_EDO_TAIL
    } nfc_state_e;
endpackage

/* src/nfc_stream_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface nfc_stream_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/nfc_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_fifo
    import nfc_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    nfc_stream_if.snk in_if,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    wire full = (cnt_reg == (AW+1)'(DEPTH));
    wire empty = (cnt_reg == '0);
    wire push = in_if.valid && !full;
    wire pop = !empty && (!out_valid || out_ready);
    assign in_if.ready = !full;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_if.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
                out_data <= mem[rd_ptr_reg];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        full |-> !push) else $error("fifo accepted a word while full");
endmodule // nfc_fifo
`default_nettype wire

/* src/nfc_host.sv */
// Contract
// - command, address, data share one io bus
// - write strobe rising edge latches bus value
// - command latch high marks command byte
// - address latch high marks address cycle
// - keep write protect low through power-up
// - five address cycles, two column three row
// - x8 plane select is A18
// - x16 column A0-A10, upper byte low
// - 00h, address, 30h starts page read
// - read data only after ready returns
// - fast cycles latch on next falling edge
// - 05h, column, E0h jumps within page
`timescale 1ns/1ns
`default_nettype none
module nfc_host
    import nfc_pkg::*;
#(
    parameter int BUS_W = 8,
    parameter int FIFO_DEPTH = 4,
    parameter int BUSY_WAIT = BUSY_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_read,
    input wire logic start_jump,
    input wire logic [ROW_W-1:0] row_addr,
    input wire logic [COL_W-1:0] col_addr,
    input wire logic [CNT_W-1:0] word_count,
    input wire logic edo_en,
    input wire logic ce_release_en,
    input wire logic wp_release,
    output logic busy,
    output logic timeout_err,
    output logic out_valid,
    output logic [BUS_W-1:0] out_data,
    input wire logic out_ready,
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic wp_n,
    output logic [BUS_W-1:0] io_out,
    output logic io_oe,
    input wire logic [BUS_W-1:0] io_in,
    input wire logic rb_n
);
    localparam logic [CNT_W-1:0] PAGE_LIMIT =
        CNT_W'((BUS_W == 16) ? PAGE_WORDS_X16 : PAGE_BYTES_X8);
    localparam logic [COL_W-1:0] COL_MASK = (BUS_W == 16) ? 12'h7ff : 12'hfff;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a level counts once stages two and three agree
    logic [2:0] rb_sync_reg;
    logic rb_lvl_reg;
    logic [BUS_W-1:0] io_s1_reg;
    logic [BUS_W-1:0] io_s2_reg;
    logic [BUS_W-1:0] io_s3_reg;
    logic [BUS_W-1:0] io_lvl_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rb_sync_reg <= 3'h0;
            rb_lvl_reg <= 1'b0;
            io_s1_reg <= '0;
            io_s2_reg <= '0;
            io_s3_reg <= '0;
            io_lvl_reg <= '0;
        end else begin
            rb_sync_reg <= {rb_sync_reg[1:0], rb_n};
            io_s1_reg <= io_in;
            io_s2_reg <= io_s1_reg;
            io_s3_reg <= io_s2_reg;
            if (rb_sync_reg[1] == rb_sync_reg[2]) begin
                rb_lvl_reg <= rb_sync_reg[2];
            end
            if (io_s2_reg == io_s3_reg) begin
                io_lvl_reg <= io_s3_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence state
    nfc_state_e state_reg, state_next;
    logic jump_reg;
    logic [2:0] item_reg;
    logic [TMR_W-1:0] tmr_reg;
    logic [31:0] wait_reg;
    logic [CNT_W-1:0] left_reg;
    logic [COL_W-1:0] col_reg;
    logic [ROW_W-1:0] row_reg;
    logic edo_reg;
    logic edo_pend_reg;
    logic wp_done_reg;

    nfc_stream_if #(.W(BUS_W)) push_if ();

    // item table: command and address cycles for both sequences
    wire [2:0] last_item = jump_reg ? 3'(JUMP_ITEMS - 1) : 3'(READ_ITEMS - 1);
    wire item_is_cmd = (item_reg == 3'h0) || (item_reg == last_item);
    wire [COL_W-1:0] col_eff = col_reg & COL_MASK;
    wire [7:0] col_hi = {4'h0, col_eff[COL_W-1:8]};
    wire [7:0] row_top = {6'h0, row_reg[ROW_W-1:16]};
    wire [7:0] cmd_byte = (item_reg == 3'h0) ?
        (jump_reg ? CMD_COL_SETUP : CMD_READ_SETUP) :
        (jump_reg ? CMD_COL_CONFIRM : CMD_READ_CONFIRM);
    // row byte 0 carries the plane bit (A18 on x8, A17 on x16) at bit 6
    wire [7:0] addr_byte = (item_reg == 3'h1) ? col_eff[7:0] :
                           (item_reg == 3'h2) ? col_hi :
                           (item_reg == 3'h3) ? row_reg[7:0] :
                           (item_reg == 3'h4) ? row_reg[15:8] :
                           row_top;
    wire [7:0] item_byte = item_is_cmd ? cmd_byte : addr_byte;
    wire [BUS_W-1:0] item_bus = BUS_W'(item_byte);
    wire [TMR_W-1:0] re_low_len = edo_reg ? TMR_W'(EDO_RE_LOW_CYC) : TMR_W'(RE_LOW_CYC);
    wire tmr_done_we_low = (tmr_reg == TMR_W'(WE_LOW_CYC - 1));
    wire tmr_done_we_high = (tmr_reg == TMR_W'(WE_HIGH_CYC - 1));
    wire tmr_done_re_low = (tmr_reg == re_low_len - 1'b1);
    wire tmr_done_re_high = (tmr_reg == TMR_W'(RE_HIGH_CYC - 1));
    wire start_any = start_read || start_jump;
    wire can_pull = push_if.ready;
    // normal mode samples at end of low phase, extended data out at next fall
    wire capture_norm = (state_reg == NFC_RE_LOW) && tmr_done_re_low && !edo_reg;
    wire capture_edo = edo_pend_reg && push_if.ready &&
        (((state_reg == NFC_RE_LOW) && (tmr_reg == '0)) || (state_reg == NFC_EDO_TAIL));
    wire capture = capture_norm || capture_edo;
    wire page_clip = (word_count > PAGE_LIMIT);
    wire [CNT_W-1:0] count_eff = page_clip ? PAGE_LIMIT : word_count;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            NFC_IDLE: begin
                if (start_any && wp_done_reg) begin
                    state_next = NFC_WE_LOW;
                end
            end
            NFC_WE_LOW: begin
                if (tmr_done_we_low) begin
                    state_next = NFC_WE_HIGH;
                end
            end
            NFC_WE_HIGH: begin
                if (tmr_done_we_high) begin
                    if (item_reg != last_item) begin
                        state_next = NFC_WE_LOW;
                    end else if (jump_reg) begin
                        state_next = (left_reg == '0) ? NFC_IDLE : NFC_RE_HIGH;
                    end else begin
                        state_next = NFC_WAIT_BUSY;
                    end
                end
            end
            NFC_WAIT_BUSY: begin
                if (!rb_lvl_reg || (wait_reg >= 32'(BUSY_WAIT))) begin
                    state_next = NFC_WAIT_READY;
                end
            end
            NFC_WAIT_READY: begin
                if (rb_lvl_reg) begin
                    state_next = (left_reg == '0) ? NFC_IDLE : NFC_RE_HIGH;
                end
            end
            NFC_RE_HIGH: begin
                if (tmr_done_re_high && can_pull) begin
                    state_next = NFC_RE_LOW;
                end
            end
            NFC_RE_LOW: begin
                if (tmr_done_re_low) begin
                    if (left_reg != CNT_W'(1)) begin
                        state_next = NFC_RE_HIGH;
                    end else begin
                        state_next = edo_reg ? NFC_EDO_TAIL : NFC_IDLE;
                    end
                end
            end
            NFC_EDO_TAIL: begin
                if (capture_edo) begin
                    state_next = NFC_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= NFC_IDLE;
            jump_reg <= 1'b0;
            item_reg <= 3'h0;
            tmr_reg <= '0;
            wait_reg <= '0;
            left_reg <= '0;
            col_reg <= '0;
            row_reg <= '0;
            edo_reg <= 1'b0;
            edo_pend_reg <= 1'b0;
            timeout_err <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= (state_next != state_reg) ? '0 : tmr_reg + 1'b1;
            wait_reg <= (state_reg == NFC_WAIT_BUSY) ? wait_reg + 32'h1 : 32'h0;
            if (state_reg == NFC_IDLE && state_next == NFC_WE_LOW) begin
                jump_reg <= !start_read;
                item_reg <= 3'h0;
                col_reg <= col_addr;
                row_reg <= start_read ? row_addr : row_reg;
                left_reg <= count_eff;
                edo_reg <= edo_en;
                edo_pend_reg <= 1'b0;
                timeout_err <= 1'b0;
            end
            if (state_reg == NFC_WE_HIGH && tmr_done_we_high) begin
                item_reg <= item_reg + 3'h1;
            end
            if (state_reg == NFC_WAIT_BUSY && rb_lvl_reg &&
                wait_reg >= 32'(BUSY_WAIT)) begin
                timeout_err <= 1'b1;
            end
            if (state_reg == NFC_RE_LOW && tmr_done_re_low) begin
                left_reg <= left_reg - 1'b1;
                if (edo_reg) begin
                    edo_pend_reg <= 1'b1;
                end
            end else if (capture_edo) begin
                edo_pend_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers, all from flip-flops
    wire drive_we = (state_next == NFC_WE_LOW) || (state_next == NFC_WE_HIGH);
    wire item_adv = (state_reg == NFC_WE_HIGH) && tmr_done_we_high;
    wire [2:0] item_next = (state_reg == NFC_IDLE) ? 3'h0 : (item_adv ? item_reg + 3'h1 : item_reg);
    wire jump_n = (state_reg == NFC_IDLE) ? !start_read : jump_reg;
    wire [2:0] last_item_n = jump_n ? 3'(JUMP_ITEMS - 1) : 3'(READ_ITEMS - 1);
    wire next_is_cmd = (item_next == 3'h0) || (item_next == last_item_n);
    wire in_wait = (state_next == NFC_WAIT_BUSY) || (state_next == NFC_WAIT_READY);
    wire ce_active = (state_next != NFC_IDLE) && !(in_wait && ce_release_en);

    // next-cycle bus value, derived from the upcoming item
    wire [7:0] item_byte_n;
    assign item_byte_n = (item_next == item_reg && jump_n == jump_reg) ? item_byte :
                         (item_next == 3'h0) ? (jump_n ? CMD_COL_SETUP : CMD_READ_SETUP) :
                         (item_next == last_item_n) ?
                             (jump_n ? CMD_COL_CONFIRM : CMD_READ_CONFIRM) :
                         (item_next == 3'h1) ? col_eff[7:0] :
                         (item_next == 3'h2) ? col_hi :
                         (item_next == 3'h3) ? row_reg[7:0] :
                         (item_next == 3'h4) ? row_reg[15:8] : row_top;
    wire [BUS_W-1:0] item_bus_n = BUS_W'(item_byte_n);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ce_n <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            we_n <= 1'b1;
            read_strobe_n <= 1'b1;
            io_out <= '0;
            io_oe <= 1'b0;
            busy <= 1'b0;
            wp_n <= 1'b0;
            wp_done_reg <= 1'b0;
        end else begin
            ce_n <= !ce_active;
            cle <= drive_we && next_is_cmd;
            ale <= drive_we && !next_is_cmd;
            we_n <= !(state_next == NFC_WE_LOW);
            read_strobe_n <= !(state_next == NFC_RE_LOW);
            io_oe <= drive_we;
            io_out <= drive_we ? item_bus_n : '0;
            busy <= (state_next != NFC_IDLE);
            if (wp_release) begin
                wp_done_reg <= 1'b1;
            end
            wp_n <= wp_done_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data into the buffer
    assign push_if.valid = capture;
    assign push_if.data = io_lvl_reg;

    nfc_fifo #(.W(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_if(push_if),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_ready(out_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_strobe_drive_cmd: assert property (@(posedge clk) disable iff (!rst_n)
        !we_n |-> io_oe && (cle ^ ale)) else $error("write strobe low without driven item");
    chk_cmd_byte_value: assert property (@(posedge clk) disable iff (!rst_n)
        (!we_n && cle && $fell(we_n)) |-> (io_out[7:0] == CMD_READ_SETUP ||
        io_out[7:0] == CMD_READ_CONFIRM || io_out[7:0] == CMD_COL_SETUP ||
        io_out[7:0] == CMD_COL_CONFIRM)) else $error("illegal command byte");
    chk_addr_upper_low: assert property (@(posedge clk) disable iff (!rst_n)
        ale |-> (io_out >> 8) == '0) else $error("address upper bits not low");
    chk_strobes_selected: assert property (@(posedge clk) disable iff (!rst_n)
        (!we_n || !read_strobe_n) |-> !ce_n) else $error("strobe while deselected");
    chk_read_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        !read_strobe_n |-> !io_oe && we_n) else $error("bus driven during read strobe");
    chk_read_after_ready: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == NFC_WAIT_READY && state_next == NFC_RE_HIGH) |-> rb_lvl_reg)
        else $error("read begun before ready");
    chk_wp_held_low: assert property (@(posedge clk) disable iff (!rst_n)
        !wp_done_reg |=> !wp_n) else $error("write protect released early");
    chk_busy_wait_bound: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == NFC_WAIT_BUSY) |-> (wait_reg <= 32'(BUSY_WAIT)))
        else $error("busy wait overrun");
    chk_edo_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (capture && edo_reg) |-> (state_reg != NFC_RE_HIGH) && edo_pend_reg)
        else $error("extended data out capture off edge");
endmodule // nfc_host
`default_nettype wire

/* verif/nfc_nand_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_nand_model
    import nfc_pkg::*;
#(
    parameter int W = 8,
    parameter int BUSY_CYC = 20
) (
    input wire logic clk,
    input wire logic no_busy,
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic [W-1:0] io_out,
    input wire logic io_oe,
    output logic [W-1:0] io_in,
    output logic rb_n
);
    logic [7:0] cmd_q [$];
    logic [7:0] adr_q [$];
    int base = 0;
    int nreads = 0;
    int bcnt = 0;
    logic [11:0] col = 12'h000;
    logic [W-1:0] drv = '0;
    logic rd_act = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // latch on write strobe rise while selected; no program or erase is accepted
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            cmd_q.push_back(io_out[7:0]);
            rd_act = 1'b0;
            if (io_out[7:0] == CMD_READ_SETUP || io_out[7:0] == CMD_COL_SETUP) begin
                base = adr_q.size();
            end
            if ((io_out[7:0] == CMD_READ_CONFIRM || io_out[7:0] == CMD_COL_CONFIRM) &&
                adr_q.size() >= base + 2) begin
                col = {adr_q[base+1][3:0], adr_q[base]};
            end
            if (io_out[7:0] == CMD_READ_CONFIRM && !no_busy) begin
                bcnt = BUSY_CYC;
            end
        end
        if (!ce_n && ale) begin
            adr_q.push_back(io_out[7:0]);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // busy keeps counting whatever chip select does
    always @(posedge clk) begin
        if (bcnt > 0) begin
            bcnt <= bcnt - 1;
        end
    end
    assign rb_n = (bcnt == 0);
    always @(negedge read_strobe_n) begin
        if (!ce_n && bcnt == 0) begin
            drv = W'(col[7:0] ^ 8'h5a);
            col = col + 12'h001;
            nreads++;
            rd_act = 1'b1;
        end
    end
    // released or deselected bus shows the inverse of the last word
    assign io_in = (!ce_n && rd_act) ? drv : ~drv;
endmodule // nfc_nand_model
`default_nettype wire

/* verif/nfc_host_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_host_tb;
    import nfc_pkg::*;
    logic clk, rst_n, start_read, start_jump, edo_en, ce_release_en, wp_release, out_ready;
    logic [ROW_W-1:0] row_addr;
    logic [COL_W-1:0] col_addr;
    logic [CNT_W-1:0] word_count;
    logic busy, timeout_err, out_valid, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, rb_n;
    logic no_busy;
    logic [7:0] out_data, io_out, io_in;
    logic [7:0] got [$];
    int fails = 0;
    int n_checks = 0;
    nfc_host #(.BUS_W(8), .FIFO_DEPTH(4), .BUSY_WAIT(10)) u_nfc_host (
        .clk(clk), .rst_n(rst_n), .start_read(start_read), .start_jump(start_jump),
        .row_addr(row_addr), .col_addr(col_addr), .word_count(word_count), .edo_en(edo_en),
        .ce_release_en(ce_release_en), .wp_release(wp_release), .busy(busy),
        .timeout_err(timeout_err), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
        .io_in(io_in), .rb_n(rb_n));
    nfc_nand_model #(.W(8), .BUSY_CYC(20)) u_nfc_nand_model (
        .clk(clk), .no_busy(no_busy), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
        .io_in(io_in), .rb_n(rb_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back(out_data);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic clear();
        got.delete();
        u_nfc_nand_model.cmd_q.delete();
        u_nfc_nand_model.adr_q.delete();
        u_nfc_nand_model.nreads = 0;
    endtask
    task automatic begin_op(input logic j, input logic [17:0] r, input logic [11:0] c,
                            input logic [11:0] n, input logic e, input logic cer);
        clear();
        @(negedge clk);
        row_addr = r;
        col_addr = c;
        word_count = n;
        edo_en = e;
        ce_release_en = cer;
        start_read = !j;
        start_jump = j;
        @(negedge clk);
        start_read = 1'b0;
        start_jump = 1'b0;
    endtask
    task automatic end_op();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            k++;
            @(negedge clk);
        end
        if (k >= 3000) begin
            fails++;
            final_report();
        end
        repeat (8) @(negedge clk);
    endtask
    task automatic chk_words(input logic [11:0] c, input int n);
        chk(16'(got.size()), 16'(n));
        for (int i = 0; i < n && i < got.size(); i++) begin
            chk({8'h00, got[i]}, {8'h00, 8'(c + 12'(i)) ^ 8'h5a});
        end
    endtask
    task automatic chk_cmds(input logic [7:0] a, input logic [7:0] b);
        chk(16'(u_nfc_nand_model.cmd_q.size()), 16'h0002);
        chk({8'h00, u_nfc_nand_model.cmd_q[0]}, {8'h00, a});
        chk({8'h00, u_nfc_nand_model.cmd_q[1]}, {8'h00, b});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_timeout();
        no_busy = 1'b1;
        begin_op(1'b0, 18'h00001, 12'h000, 12'h002, 1'b0, 1'b0);
        end_op();
        chk({15'h0, timeout_err}, 16'h0001);
        chk(16'(u_nfc_nand_model.nreads), 16'h0002);
        chk_words(12'h000, 2);
        no_busy = 1'b0;
    endtask
    task automatic t_read();
        logic [17:0] r;
        logic [11:0] c;
        logic [7:0] eb [5];
        r = 18'h23c45;
        c = 12'h9ab;
        eb = '{c[7:0], {4'h0, c[11:8]}, r[7:0], r[15:8], {6'h00, r[17:16]}};
        begin_op(1'b0, r, c, 12'h005, 1'b0, 1'b0);
        end_op();
        chk({15'h0, timeout_err}, 16'h0000);
        chk_cmds(8'h00, 8'h30);
        chk(16'(u_nfc_nand_model.adr_q.size()), 16'h0005);
        for (int i = 0; i < 5; i++) begin
            chk({8'h00, u_nfc_nand_model.adr_q[i]}, {8'h00, eb[i]});
        end
        chk_words(c, 5);
    endtask
    task automatic t_jump();
        begin_op(1'b1, 18'h00000, 12'h47f, 12'h003, 1'b0, 1'b0);
        end_op();
        chk_cmds(8'h05, 8'he0);
        chk(16'(u_nfc_nand_model.adr_q.size()), 16'h0002);
        chk({8'h00, u_nfc_nand_model.adr_q[1]}, 16'h0004);
        chk_words(12'h47f, 3);
    endtask
    task automatic t_edo();
        begin_op(1'b0, 18'h00100, 12'h0fe, 12'h004, 1'b1, 1'b1);
        end_op();
        chk_cmds(8'h00, 8'h30);
        chk_words(12'h0fe, 4);
    endtask
    task automatic t_fifo();
        out_ready = 1'b0;
        begin_op(1'b0, 18'h00002, 12'h010, 12'h008, 1'b0, 1'b0);
        repeat (300) @(negedge clk);
        chk({15'h0, u_nfc_nand_model.nreads < 8}, 16'h0001);
        chk({15'h0, u_nfc_nand_model.nreads >= 4}, 16'h0001);
        out_ready = 1'b1;
        end_op();
        chk_words(12'h010, 8);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        start_read = 1'b0;
        start_jump = 1'b0;
        row_addr = '0;
        col_addr = '0;
        word_count = '0;
        edo_en = 1'b0;
        ce_release_en = 1'b0;
        wp_release = 1'b0;
        out_ready = 1'b1;
        no_busy = 1'b0;
        repeat (20) @(negedge clk);
        chk({15'h0, wp_n}, 16'h0000);
        chk({15'h0, ce_n}, 16'h0001);
        rst_n = 1'b1;
        @(negedge clk);
        wp_release = 1'b1;
        @(negedge clk);
        wp_release = 1'b0;
        repeat (4) @(negedge clk);
        t_timeout();
        t_read();
        t_jump();
        t_edo();
        t_fifo();
        final_report();
    end
endmodule // nfc_host_tb
`default_nettype wire
